// ===== hbc_dual_hbridge.sv
// Dual H-bridge control logic: decode, chopping, sleep and fault handling
// Functional notes
// - Each bridge obeys only its own inputs
// - Both inputs low: both outputs released
// - Low then high input: reverse drive
// - Forward on high-low; brake on both high
// - Slow decay: both low sides on
// - Chopping stays active under external PWM
// - Sense trip ends the drive phase
// - Fixed slow-decay off time, then drive again
// - Ignore sense during blanking after enable
// - Sleep releases outputs and resets logic
// - Direction inputs ignored while asleep
// - Sleep entered only after entry delay
// - No output change until wake delay, unless sleep is asked again while waking
// - Persistent overcurrent disables that bridge
// - Overcurrent shutdown retries after fixed period
// - Overcurrent affects only its own bridge
// - Overcurrent path separate from sense path
// - Overheat disables all, resumes when clear
// - Low supply resets all, resumes after
// - Dead time between switching transitions
`timescale 1ns/1ns
`default_nettype none
module hbc_dual_hbridge #(
   // Durations in clock cycles
   parameter logic [17:0] BLANK_CYCLES = hbc_pkg::BLANK_CYCLES,
   parameter logic [17:0] OFF_CYCLES = hbc_pkg::OFF_CYCLES,
   parameter logic [17:0] OC_FILTER_CYCLES = hbc_pkg::OC_FILTER_CYCLES,
   parameter logic [17:0] OC_RETRY_CYCLES = hbc_pkg::OC_RETRY_CYCLES,
   parameter logic [17:0] DEAD_CYCLES = hbc_pkg::DEAD_CYCLES,
   parameter logic [17:0] SLEEP_ENTRY_CYCLES = hbc_pkg::SLEEP_ENTRY_CYCLES,
   parameter logic [17:0] WAKE_CYCLES = hbc_pkg::WAKE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sleep request pin, low asks for sleep
   input wire logic sleepRequestN,
   // Bridge A direction inputs
   input wire logic bridgeADirInFirst,
   input wire logic bridgeADirInSecond,
   // Bridge B direction inputs
   input wire logic bridgeBDirInFirst,
   input wire logic bridgeBDirInSecond,
   // Sense comparator trips, high at the reference level
   input wire logic bridgeACurrentSense,
   input wire logic bridgeBCurrentSense,
   // Analog current limit active, per bridge
   input wire logic bridgeAOvercurrentGuard,
   input wire logic bridgeBOvercurrentGuard,
   // Overheat and low-supply indications
   input wire logic overheatShutdown,
   input wire logic supplyLowLockout,
   // Bridge A outputs, level and active-low enable
   output logic bridgeADriveFirst,
   output logic bridgeADriveFirstOeN,
   output logic bridgeADriveSecond,
   output logic bridgeADriveSecondOeN,
   // Bridge B outputs, level and active-low enable
   output logic bridgeBDriveFirst,
   output logic bridgeBDriveFirstOeN,
   output logic bridgeBDriveSecond,
   output logic bridgeBDriveSecondOeN,
   // Status
   output logic deviceAwake,
   output logic bridgeAOvercurrentOff,
   output logic bridgeBOvercurrentOff
);
   // Whole state of the top level
   typedef struct packed {
      hbc_pkg::hbc_mode_t mode;
      logic [17:0] modeCnt;
      hbc_pkg::hbc_bridge_t [1:0] br;
      logic awake;
      logic [1:0] ocOff;
   } hbc_top_t;

   // State after reset or a low supply; wake delay applies at power-up
   localparam hbc_top_t TOP_RESET = '{mode: hbc_pkg::MODE_WAKING, modeCnt: 18'h00000,
      br: {hbc_pkg::BRIDGE_RESET, hbc_pkg::BRIDGE_RESET}, awake: 1'b0, ocOff: 2'h0};

   hbc_top_t s; // Current state
   hbc_top_t next_s; // Next state
   logic [10:0] pinSync; // Synchronised pin inputs
   logic sleepN; // Synchronised sleep request
   logic [1:0] cmd [2]; // Direction pair per bridge
   logic [1:0] trip; // Sense trip per bridge
   logic [1:0] ocGuard; // Current limit per bridge
   logic overheat; // Synchronised overheat
   logic supplyLow; // Synchronised low supply
   logic run; // Bridges may operate
   logic [1:0] halfReq [4]; // Requests for the four halves
   logic [3:0] halfLevel; // Half output levels
   logic [3:0] halfOeN; // Half output enables

   // Two flops per pin; sleep inverted so a reset stage means no request
   hbc_sync #(
      .W(11)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .asyncIn({~sleepRequestN, bridgeADirInFirst, bridgeADirInSecond,
                bridgeBDirInFirst, bridgeBDirInSecond, bridgeACurrentSense,
                bridgeBCurrentSense, bridgeAOvercurrentGuard,
                bridgeBOvercurrentGuard, overheatShutdown, supplyLowLockout}),
      .syncOut(pinSync)
   );

   // Split the synchronised pins; each bridge gets its own pair
   assign sleepN = ~pinSync[10];
   assign cmd[0] = pinSync[9:8];
   assign cmd[1] = pinSync[7:6];
   assign trip = {pinSync[4], pinSync[5]};
   assign ocGuard = {pinSync[2], pinSync[3]};
   assign overheat = pinSync[1];
   assign supplyLow = pinSync[0];

   // Advance one bridge: overcurrent guard and chopping phases
   function automatic hbc_pkg::hbc_bridge_t bridge_step(
      input hbc_pkg::hbc_bridge_t cur,
      input logic [1:0] dir,
      input logic senseTrip,
      input logic limit,
      input logic enable
   );
      hbc_pkg::hbc_bridge_t n;
      logic driving;
      n = cur;
      // Guard watches its own limit signal, not the sense trip
      case (cur.oc)
         hbc_pkg::OC_CLEAR:
         begin
            // Limit seen, start the filter
            if (limit)
            begin
               n.oc = hbc_pkg::OC_FILTER;
               n.ocCnt = 18'h00000;
            end
         end
         hbc_pkg::OC_FILTER:
         begin
            // Short limit pulses are forgotten
            if (!limit)
            begin
               n.oc = hbc_pkg::OC_CLEAR;
            end
            else if (cur.ocCnt >= OC_FILTER_CYCLES - 18'h00001)
            begin
               // Limit persisted, shut this bridge
               n.oc = hbc_pkg::OC_OFF;
               n.ocCnt = 18'h00000;
            end
            else
            begin
               n.ocCnt = cur.ocCnt + 18'h00001;
            end
         end
         hbc_pkg::OC_OFF:
         begin
            // Retry after the fixed period
            if (cur.ocCnt >= OC_RETRY_CYCLES - 18'h00001)
            begin
               n.oc = hbc_pkg::OC_CLEAR;
               n.ocCnt = 18'h00000;
            end
            else
            begin
               n.ocCnt = cur.ocCnt + 18'h00001;
            end
         end
         default:
         begin
            n.oc = hbc_pkg::OC_CLEAR;
            n.ocCnt = 18'h00000;
         end
      endcase
      // Chopping runs whenever a drive pattern is applied
      driving = enable && (cur.oc != hbc_pkg::OC_OFF) &&
                (dir == hbc_pkg::CMD_FORWARD || dir == hbc_pkg::CMD_REVERSE);
      if (!driving)
      begin
         // Coast, brake or disabled: no chopping
         n.chop = hbc_pkg::CH_IDLE;
         n.chopCnt = 18'h00000;
      end
      else if (cur.chop == hbc_pkg::CH_IDLE || dir != cur.lastCmd)
      begin
         // Output newly enabled, start blanking
         n.chop = hbc_pkg::CH_BLANK;
         n.chopCnt = 18'h00000;
      end
      else
      begin
         case (cur.chop)
            hbc_pkg::CH_BLANK:
            begin
               // Sense ignored until blanking ends
               if (cur.chopCnt >= BLANK_CYCLES - 18'h00001)
               begin
                  n.chop = hbc_pkg::CH_SENSE;
                  n.chopCnt = 18'h00000;
               end
               else
               begin
                  n.chopCnt = cur.chopCnt + 18'h00001;
               end
            end
            hbc_pkg::CH_SENSE:
            begin
               // Trip ends the drive phase
               if (senseTrip)
               begin
                  n.chop = hbc_pkg::CH_OFF;
                  n.chopCnt = 18'h00000;
               end
            end
            hbc_pkg::CH_OFF:
            begin
               // Hold slow decay, then drive again with blanking
               if (cur.chopCnt >= OFF_CYCLES - 18'h00001)
               begin
                  n.chop = hbc_pkg::CH_BLANK;
                  n.chopCnt = 18'h00000;
               end
               else
               begin
                  n.chopCnt = cur.chopCnt + 18'h00001;
               end
            end
            default:
            begin
               n.chop = hbc_pkg::CH_IDLE;
               n.chopCnt = 18'h00000;
            end
         endcase
      end
      // Remember the pattern to spot a new enable
      n.lastCmd = enable ? dir : hbc_pkg::CMD_COAST;
      return n;
   endfunction

   // Requested halves {first, second} for one bridge
   function automatic logic [3:0] bridge_halves(
      input hbc_pkg::hbc_bridge_t cur,
      input logic [1:0] dir,
      input logic drive
   );
      logic [3:0] h;
      if (!drive || cur.oc == hbc_pkg::OC_OFF)
      begin
         // Disabled or overcurrent: all switches off
         h = {hbc_pkg::HALF_Z, hbc_pkg::HALF_Z};
      end
      else if (cur.chop == hbc_pkg::CH_OFF)
      begin
         // Off time: both low sides on, high sides off
         h = {hbc_pkg::HALF_LOW, hbc_pkg::HALF_LOW};
      end
      else
      begin
         case (dir)
            // Coast, fast decay
            hbc_pkg::CMD_COAST: h = {hbc_pkg::HALF_Z, hbc_pkg::HALF_Z};
            // Reverse
            hbc_pkg::CMD_REVERSE: h = {hbc_pkg::HALF_LOW, hbc_pkg::HALF_HIGH};
            // Forward
            hbc_pkg::CMD_FORWARD: h = {hbc_pkg::HALF_HIGH, hbc_pkg::HALF_LOW};
            // Brake, slow decay
            hbc_pkg::CMD_BRAKE: h = {hbc_pkg::HALF_LOW, hbc_pkg::HALF_LOW};
            default: h = {hbc_pkg::HALF_Z, hbc_pkg::HALF_Z};
         endcase
      end
      return h;
   endfunction

   // Bridges work in active mode and during sleep entry; overheat stops all
   assign run = (s.mode == hbc_pkg::MODE_ACTIVE || s.mode == hbc_pkg::MODE_ENTER) &&
                !overheat && !supplyLow;

   // Power mode sequencing and bridge update
   always_comb
   begin
      next_s = s;
      case (s.mode)
         hbc_pkg::MODE_ACTIVE:
         begin
            // Sleep request starts the entry delay
            if (!sleepN)
            begin
               next_s.mode = hbc_pkg::MODE_ENTER;
               next_s.modeCnt = 18'h00000;
            end
         end
         hbc_pkg::MODE_ENTER:
         begin
            if (sleepN)
            begin
               // Request withdrawn, stay active
               next_s.mode = hbc_pkg::MODE_ACTIVE;
            end
            else if (s.modeCnt >= SLEEP_ENTRY_CYCLES - 18'h00001)
            begin
               // Entry delay served
               next_s.mode = hbc_pkg::MODE_ASLEEP;
               next_s.modeCnt = 18'h00000;
            end
            else
            begin
               next_s.modeCnt = s.modeCnt + 18'h00001;
            end
         end
         hbc_pkg::MODE_ASLEEP:
         begin
            // Only the sleep pin is watched here
            if (sleepN)
            begin
               next_s.mode = hbc_pkg::MODE_WAKING;
               next_s.modeCnt = 18'h00000;
            end
         end
         hbc_pkg::MODE_WAKING:
         begin
            if (!sleepN)
            begin
               // Sleep asked again before wake finished
               next_s.mode = hbc_pkg::MODE_ENTER;
               next_s.modeCnt = 18'h00000;
            end
            else if (s.modeCnt >= WAKE_CYCLES - 18'h00001)
            begin
               // Wake delay served, outputs may now change
               next_s.mode = hbc_pkg::MODE_ACTIVE;
               next_s.modeCnt = 18'h00000;
            end
            else
            begin
               next_s.modeCnt = s.modeCnt + 18'h00001;
            end
         end
         default:
         begin
            next_s.mode = hbc_pkg::MODE_WAKING;
            next_s.modeCnt = 18'h00000;
         end
      endcase
      if (s.mode == hbc_pkg::MODE_ASLEEP || s.mode == hbc_pkg::MODE_WAKING)
      begin
         // Asleep or waking: bridge logic held in reset, timers still
         next_s.br = {hbc_pkg::BRIDGE_RESET, hbc_pkg::BRIDGE_RESET};
      end
      else
      begin
         // Each bridge from its own inputs only
         next_s.br[0] = bridge_step(s.br[0], cmd[0], trip[0], ocGuard[0], run);
         next_s.br[1] = bridge_step(s.br[1], cmd[1], trip[1], ocGuard[1], run);
      end
      if (supplyLow)
      begin
         // Low supply: everything back to reset until it recovers
         next_s = TOP_RESET;
      end
      // Registered status
      next_s.awake = (next_s.mode == hbc_pkg::MODE_ACTIVE);
      next_s.ocOff = {next_s.br[1].oc == hbc_pkg::OC_OFF,
                      next_s.br[0].oc == hbc_pkg::OC_OFF};
   end

   // Register the state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= TOP_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Half requests; released while asleep or waking
   always_comb
   begin
      {halfReq[0], halfReq[1]} = bridge_halves(s.br[0], cmd[0], run);
      {halfReq[2], halfReq[3]} = bridge_halves(s.br[1], cmd[1], run);
   end

   // Dead time and output registers for each half
   for (genvar i = 0; i < 4; i++)
   begin : g_half
      hbc_dead_time #(
         .DEAD_CYCLES(DEAD_CYCLES)
      ) u_dead (
         .clk(clk),
         .rst(rst),
         .halfReq(halfReq[i]),
         .halfLevel(halfLevel[i]),
         .halfOeN(halfOeN[i])
      );
   end

   // Output pins
   assign {bridgeBDriveSecond, bridgeBDriveFirst, bridgeADriveSecond,
           bridgeADriveFirst} = halfLevel;
   assign {bridgeBDriveSecondOeN, bridgeBDriveFirstOeN, bridgeADriveSecondOeN,
           bridgeADriveFirstOeN} = halfOeN;
   assign deviceAwake = s.awake;
   assign {bridgeBOvercurrentOff, bridgeAOvercurrentOff} = s.ocOff;
endmodule
`default_nettype wire

// ===== hbc_pkg.sv
// Shared constants and types for the dual H-bridge control logic
`default_nettype none
package hbc_pkg;
   // Clock period of the internal oscillator
   localparam int CLK_PERIOD_NS = 10;
   // Durations in nanoseconds
   localparam int BLANK_TIME_NS = 3750;
   localparam int OFF_TIME_NS = 20000;
   localparam int OC_FILTER_NS = 2300;
   localparam int OC_RETRY_NS = 1400000;
   localparam int DEAD_TIME_NS = 450;
   localparam int SLEEP_ENTRY_NS = 1000;
   localparam int WAKE_TIME_NS = 1000;
   // Round a duration up to whole clock cycles
   function automatic logic [17:0] to_cycles(input int ns);
      return 18'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction
   localparam logic [17:0] BLANK_CYCLES = to_cycles(BLANK_TIME_NS);
   localparam logic [17:0] OFF_CYCLES = to_cycles(OFF_TIME_NS);
   localparam logic [17:0] OC_FILTER_CYCLES = to_cycles(OC_FILTER_NS);
   localparam logic [17:0] OC_RETRY_CYCLES = to_cycles(OC_RETRY_NS);
   localparam logic [17:0] DEAD_CYCLES = to_cycles(DEAD_TIME_NS);
   localparam logic [17:0] SLEEP_ENTRY_CYCLES = to_cycles(SLEEP_ENTRY_NS);
   localparam logic [17:0] WAKE_CYCLES = to_cycles(WAKE_TIME_NS);
   // Half-bridge drive requests
   localparam logic [1:0] HALF_Z = 2'h0;
   localparam logic [1:0] HALF_LOW = 2'h1;
   localparam logic [1:0] HALF_HIGH = 2'h2;
   // Direction input pairs, first input in the upper bit
   localparam logic [1:0] CMD_COAST = 2'h0;
   localparam logic [1:0] CMD_REVERSE = 2'h1;
   localparam logic [1:0] CMD_FORWARD = 2'h2;
   localparam logic [1:0] CMD_BRAKE = 2'h3;
   // Device power modes
   typedef enum logic [1:0] {MODE_ACTIVE, MODE_ENTER, MODE_ASLEEP, MODE_WAKING} hbc_mode_t;
   // Current chopping phases
   typedef enum logic [1:0] {CH_IDLE, CH_BLANK, CH_SENSE, CH_OFF} hbc_chop_t;
   // Overcurrent guard phases
   typedef enum logic [1:0] {OC_CLEAR, OC_FILTER, OC_OFF} hbc_oc_t;
   // Per-bridge state
   typedef struct packed {
      hbc_chop_t chop;
      hbc_oc_t oc;
      logic [1:0] lastCmd;
      logic [17:0] chopCnt;
      logic [17:0] ocCnt;
   } hbc_bridge_t;
   // Bridge state after reset or sleep
   localparam hbc_bridge_t BRIDGE_RESET = '{chop: CH_IDLE, oc: OC_CLEAR, lastCmd: CMD_COAST,
      chopCnt: 18'h00000, ocCnt: 18'h00000};
endpackage
`default_nettype wire

// ===== hbc_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module hbc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous inputs and their synchronised copy
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   // Both stages held in one struct
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } hbc_sync_t;
   hbc_sync_t s; // Current stages
   hbc_sync_t next_s; // Next stages

   // Shift the inputs through the two stages
   always_comb
   begin
      next_s.stage1 = asyncIn;
      next_s.stage2 = s.stage1;
   end

   // Register the stages
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign syncOut = s.stage2;
endmodule
`default_nettype wire

// ===== hbc_dead_time.sv
// Dead-time insertion for one half-bridge output
`timescale 1ns/1ns
`default_nettype none
module hbc_dead_time #(
   parameter logic [17:0] DEAD_CYCLES = hbc_pkg::DEAD_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Requested drive of this half
   input wire logic [1:0] halfReq,
   // Output pin level and active-low enable
   output logic halfLevel,
   output logic halfOeN
);
   // Applied drive, idle counter and registered pin signals
   typedef struct packed {
      logic [1:0] applied;
      logic [17:0] cnt;
      logic level;
      logic oeN;
   } hbc_dead_t;
   hbc_dead_t s; // Current state
   hbc_dead_t next_s; // Next state

   // Turn off at once, turn on only after the dead time off
   always_comb
   begin
      next_s = s;
      // Count idle cycles while released, saturating
      if (s.applied == hbc_pkg::HALF_Z && s.cnt < DEAD_CYCLES)
      begin
         next_s.cnt = s.cnt + 18'h00001;
      end
      if (halfReq != s.applied)
      begin
         if (s.applied != hbc_pkg::HALF_Z)
         begin
            // Release the switch first
            next_s.applied = hbc_pkg::HALF_Z;
            next_s.cnt = 18'h00000;
         end
         else if (s.cnt >= DEAD_CYCLES)
         begin
            // Dead time served, drive the new level
            next_s.applied = halfReq;
         end
      end
      next_s.level = (next_s.applied == hbc_pkg::HALF_HIGH);
      next_s.oeN = (next_s.applied == hbc_pkg::HALF_Z);
   end

   // Register the state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '{applied: hbc_pkg::HALF_Z, cnt: 18'h00000, level: 1'b0, oeN: 1'b1};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign halfLevel = s.level;
   assign halfOeN = s.oeN;
endmodule
`default_nettype wire

// ===== hbc_dual_hbridge_asserts.sv
// Concurrent checks on the dual H-bridge ports
`timescale 1ns/1ns
`default_nettype none
module hbc_dual_hbridge_asserts #(
   parameter logic [17:0] OC_RETRY_CYCLES = hbc_pkg::OC_RETRY_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs watched
   input wire logic sleepRequestN,
   input wire logic bridgeADirInFirst,
   input wire logic bridgeADirInSecond,
   input wire logic bridgeAOvercurrentGuard,
   input wire logic overheatShutdown,
   input wire logic supplyLowLockout,
   // Outputs watched
   input wire logic bridgeADriveFirst,
   input wire logic bridgeADriveFirstOeN,
   input wire logic bridgeADriveSecond,
   input wire logic bridgeADriveSecondOeN,
   input wire logic deviceAwake,
   input wire logic bridgeAOvercurrentOff
);
   // Cycles after the rise that the retry flag must stay high
   localparam int RLO = int'(OC_RETRY_CYCLES) - 2;
   // Bridge A fully released
   wire aRel = bridgeADriveFirstOeN && bridgeADriveSecondOeN;
   // Brake asked on A with no fault in the way
   wire aBrk = bridgeADirInFirst && bridgeADirInSecond && !overheatShutdown
      && !supplyLowLockout && !bridgeAOvercurrentGuard;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Steady brake while awake
   sequence s_braking; (aBrk && deviceAwake && !bridgeAOvercurrentOff)[*8]; endsequence
   // Sleep pin low long enough to sleep, then raised
   sequence s_asleep; !sleepRequestN[*8] ##1 !sleepRequestN[*4]; endsequence
   sequence s_woken; s_asleep ##1 sleepRequestN[*5]; endsequence
   a_coast_release: assert property ((!bridgeADirInFirst && !bridgeADirInSecond)[*5] |-> aRel)
      else $error("bridge A driven during coast");
   a_brake_lows: assert property (s_braking |-> !bridgeADriveFirstOeN
      && !bridgeADriveSecondOeN && !bridgeADriveFirst && !bridgeADriveSecond)
      else $error("bridge A not braking");
   a_entry_delay: assert property (s_braking ##0 $fell(sleepRequestN)
      ##1 (aBrk && !sleepRequestN)[*4] |-> !bridgeADriveFirstOeN)
      else $error("drive dropped before sleep delay");
   a_sleep_release: assert property (s_asleep |-> aRel && !deviceAwake)
      else $error("bridge A driven while asleep");
   a_wake_hold: assert property (s_woken |-> aRel && !deviceAwake)
      else $error("drive before wake delay");
   a_heat_release: assert property (overheatShutdown[*5] |-> aRel)
      else $error("bridge A driven while overheated");
   a_oc_trip: assert property ((bridgeAOvercurrentGuard && deviceAwake)[*8]
      |-> ##[0:8] bridgeAOvercurrentOff)
      else $error("overcurrent not latched");
   a_oc_released: assert property (bridgeAOvercurrentOff[*2] |-> aRel)
      else $error("bridge A driven in overcurrent wait");
   a_oc_retry: assert property ($rose(bridgeAOvercurrentOff)
      |-> (bridgeAOvercurrentOff throughout ##RLO 1'b1) ##[1:4] !bridgeAOvercurrentOff)
      else $error("overcurrent retry period wrong");
endmodule
bind hbc_dual_hbridge hbc_dual_hbridge_asserts #(.OC_RETRY_CYCLES(OC_RETRY_CYCLES))
   i_hbc_dual_hbridge_asserts (.*);
`default_nettype wire

// ===== hbc_host_model.sv
// Host controller model driving the direction and sleep pins
`timescale 1ns/1ns
`default_nettype none
module hbc_host_model (
   // Clock
   input wire logic clk,
   // Requested pairs, first input in the upper bit, and sleep
   input wire logic [1:0] cmdA,
   input wire logic [1:0] cmdB,
   input wire logic wantSleep,
   // Pins towards the device
   output logic aF,
   output logic aS,
   output logic bF,
   output logic bS,
   output logic slpN
);
   // Idle pins until the first edge
   initial
   begin
      {aF, aS, bF, bS, slpN} = 5'h01;
   end
   // Pins move just after the edge, whole pairs at once
   always @(posedge clk)
   begin
      {aF, aS} <= cmdA;
      {bF, bS} <= cmdB;
      slpN <= ~wantSleep;
   end
endmodule
`default_nettype wire

// ===== hbc_dual_hbridge_tb_top.sv
// Self-checking bench for the dual H-bridge control logic
`timescale 1ns/1ns
`default_nettype none
module hbc_dual_hbridge_tb_top;
   // Expected {off1, level1, off2, level2} per pin pair
   localparam logic [3:0] EXP [4] = '{4'hA, 4'h1, 4'h4, 4'h0};
   // Clock, reset and counters
   logic clk = 1'b0;
   logic rst = 1'b1;
   int errors = 0;
   int compares = 0;
   // Host requests and analog indications
   logic [1:0] cmdA = 2'h0;
   logic [1:0] cmdB = 2'h0;
   logic wantSleep = 1'b0;
   logic senseA = 1'b0;
   logic guardA = 1'b0;
   logic guardB = 1'b0;
   logic heat = 1'b0;
   logic lowSupply = 1'b0;
   // Pins and device outputs
   wire aF, aS, bF, bS, slpN;
   logic oA1, nA1, oA2, nA2, oB1, nB1, oB2, nB2, awake, ocA, ocB;
   // Free-running clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   hbc_host_model i_hbc_host_model (.clk(clk), .cmdA(cmdA), .cmdB(cmdB),
      .wantSleep(wantSleep), .aF(aF), .aS(aS), .bF(bF), .bS(bS), .slpN(slpN));
   hbc_dual_hbridge #(.BLANK_CYCLES(18'h5), .OFF_CYCLES(18'h14), .OC_FILTER_CYCLES(18'h4),
      .OC_RETRY_CYCLES(18'h32), .DEAD_CYCLES(18'h3), .SLEEP_ENTRY_CYCLES(18'h5),
      .WAKE_CYCLES(18'h5)) i_hbc_dual_hbridge (.clk(clk), .rst(rst), .sleepRequestN(slpN),
      .bridgeADirInFirst(aF), .bridgeADirInSecond(aS), .bridgeBDirInFirst(bF),
      .bridgeBDirInSecond(bS), .bridgeACurrentSense(senseA), .bridgeBCurrentSense(senseA),
      .bridgeAOvercurrentGuard(guardA), .bridgeBOvercurrentGuard(guardB),
      .overheatShutdown(heat), .supplyLowLockout(lowSupply), .bridgeADriveFirst(oA1),
      .bridgeADriveFirstOeN(nA1), .bridgeADriveSecond(oA2), .bridgeADriveSecondOeN(nA2),
      .bridgeBDriveFirst(oB1), .bridgeBDriveFirstOeN(nB1), .bridgeBDriveSecond(oB2),
      .bridgeBDriveSecondOeN(nB2), .deviceAwake(awake), .bridgeAOvercurrentOff(ocA),
      .bridgeBOvercurrentOff(ocB));
   // Released halves read as level 0
   wire [3:0] outA = {nA1, oA1 & ~nA1, nA2, oA2 & ~nA2};
   wire [3:0] outB = {nB1, oB1 & ~nB1, nB2, oB2 & ~nB2};
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Compare a four-bit result
   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Compare a count with a window
   task automatic chkCnt(input int got, input int lo, input int hi, input string what);
      compares++;
      if (got < lo || got > hi)
      begin
         errors++;
         $display("unexpected at %0t: %s took %0d cycles", $time, what, got);
      end
   endtask
   // Bounded wait for awake (sel 0) or end of overcurrent wait (sel 1)
   task automatic waitFor(input bit sel, output int n);
      n = 0;
      while ((sel ? ocA : ~awake) !== 1'b0 && n < 60)
      begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_decode();
      for (int c = 0; c < 4; c++)
      begin
         cmdA <= 2'(c);
         cmdB <= 2'(3 - c);
         cyc(14);
         chk(outA, EXP[c], "A decode");
         chk(outB, EXP[3 - c], "B decode");
      end
      $display("test decode done");
   endtask
   task automatic t_chop();
      cmdA <= 2'h0;
      cyc(10);
      cmdA <= 2'h2;
      cyc(2);
      senseA <= 1'b1;
      cyc(2);
      senseA <= 1'b0;
      cyc(10);
      chk(outA, 4'h4, "trip in blanking");
      senseA <= 1'b1;
      cyc(1);
      senseA <= 1'b0;
      cyc(8);
      chk(outA, 4'h0, "trip decay");
      cyc(10);
      chk(outA, 4'h0, "off time held");
      cyc(15);
      chk(outA, 4'h4, "after off time");
      $display("test chop done");
   endtask
   task automatic t_oc();
      int n;
      cmdA <= 2'h3;
      cmdB <= 2'h3;
      cyc(14);
      guardA <= 1'b1;
      guardB <= 1'b1;
      cyc(2);
      guardB <= 1'b0;
      cyc(10);
      guardA <= 1'b0;
      chk(outA, 4'hA, "A overcurrent");
      chk({outB[3:1], ocB}, 4'h0, "B short pulse");
      waitFor(1'b1, n);
      chkCnt(n, 40, 50, "overcurrent retry");
      cyc(6);
      chk(outA, 4'h0, "A resumed");
      $display("test overcurrent done");
   endtask
   task automatic t_heat();
      heat <= 1'b1;
      cyc(8);
      chk({outA[3], outA[1], outB[3], outB[1]}, 4'hF, "heat release");
      heat <= 1'b0;
      cyc(8);
      chk(outA, 4'h0, "heat resume");
      $display("test overheat done");
   endtask
   task automatic t_supply();
      int n;
      lowSupply <= 1'b1;
      cyc(6);
      chk({awake, outA[3], outB[3], 1'b0}, 4'h6, "supply reset");
      lowSupply <= 1'b0;
      waitFor(1'b0, n);
      chkCnt(n, 7, 12, "supply recovery");
      cyc(6);
      chk(outA, 4'h0, "recovery drive");
      $display("test supply done");
   endtask
   task automatic t_sleep();
      int n;
      wantSleep <= 1'b1;
      cyc(5);
      chk(outA, 4'h0, "entry delay");
      cyc(10);
      chk({awake, outA[3], outA[1], 1'b0}, 4'h6, "asleep");
      cmdA <= 2'h2;
      cyc(10);
      chk(outA, 4'hA, "asleep pins");
      wantSleep <= 1'b0;
      cyc(5);
      chk(outA, 4'hA, "wake hold");
      waitFor(1'b0, n);
      cyc(12);
      chk(outA, 4'h4, "after wake");
      $display("test sleep done");
   endtask
   // Verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      cyc(2);
      rst <= 1'b0;
      cyc(20);
      chk({awake, 3'h0}, 4'h8, "awake after reset");
      t_decode();
      t_chop();
      t_oc();
      t_heat();
      t_supply();
      t_sleep();
      end_of_test();
   end
   // Hang guard
   initial
   begin
      #20000;
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
`default_nettype wire
